// ---- scm_chk_monitor.sv ----
// Checker of the monitor register port, flags and supply reset
`timescale 1ns/1ps
`include "scm_regs.svh"
module scm_chk
  import scm_pkg::*;
(
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        reset_n,
  // Register port
  input wire logic        reg_rd_en,
  input wire logic [5:0]  reg_addr,
  input wire logic [7:0]  reg_rdata_q,
  input wire logic        reg_rvalid_q,
  // Device inputs and state
  input wire scm_events_t events,
  input wire scm_supply_t supply,
  input wire logic        init_done,
  input wire logic        device_reset_q,
  input wire logic        initializing_flag_q,
  input wire logic [7:0]  status_register_q
);
  // ********************
  // Helpers and assertions
  // ********************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic live_q;
  wire  sup_ok = supply.vext_ok & supply.vreg_ok & supply.vrega_ok &
                 !(supply.dreg_fault & supply.dreg_hold_mode);
  wire  ok = live_q & !device_reset_q & sup_ok;
  // Device has been out of reset for a whole cycle
  always_ff @(posedge core_clk) live_q <= reset_n & !device_reset_q;
  read_answered_a:
    assert property (reg_rd_en & ok |=> reg_rvalid_q)
    else $error("read not answered");
  valid_needs_read_a:
    assert property (reg_rvalid_q |-> $past(reg_rd_en))
    else $error("answer without read");
  top_bit_zero_a:
    assert property (reg_rvalid_q && $past(reg_addr) == `SCM_OFF_STATUS
                     |-> !reg_rdata_q[7]) else $error("status bit 7 set");
  sat_sets_a:
    assert property ((events.sat_x | events.sat_y) & ok
                     |-> ##2 status_register_q[5]) else $error("no sat");
  mismatch_sets_a:
    assert property (events.miso_mismatch & ok |=> ##1 status_register_q[3])
    else $error("no mismatch flag");
  offset_sets_a:
    assert property (events.off_lim_y & ok |-> ##2 status_register_q[2])
    else $error("no offset flag");
  init_kept_a:
    assert property (reg_rd_en & initializing_flag_q & !init_done & ok
                     |=> initializing_flag_q) else $error("init lost");
  init_ends_a:
    assert property (init_done & initializing_flag_q & ok
                     |-> ##[1:2] !initializing_flag_q) else $error("init");
  supply_reset_a:
    assert property (!sup_ok |-> ##[1:2] device_reset_q)
    else $error("no supply reset");
  dreg_flag_a:
    assert property (supply.dreg_fault & ok |-> ##[1:3] status_register_q[0])
    else $error("no reset flag");
  // Main scenarios reached
  cover property (reg_rvalid_q && $past(reg_addr) == `SCM_OFF_STATUS);
  cover property (status_register_q[6]);
  cover property ($rose(device_reset_q));
endmodule
bind scm_monitor scm_chk u_chk (.core_clk(core_clk), .reset_n(reset_n),
  .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_rdata_q(reg_rdata_q),
  .reg_rvalid_q(reg_rvalid_q), .events(events), .supply(supply),
  .init_done(init_done), .device_reset_q(device_reset_q),
  .initializing_flag_q(initializing_flag_q),
  .status_register_q(status_register_q));

// ---- scm_crc3_check.sv ----
// Background 3-bit CRC checker over a byte array
`timescale 1ns/1ps
`include "scm_regs.svh"

module scm_crc3_check
  import scm_pkg::*;
#(
  parameter int NBYTES = 8
) (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  reset_n,
  // Array under check
  input  wire logic                  enable,
  input  wire logic [NBYTES*8-1:0]   data,
  input  wire logic [2:0]            check_bits,
  // Result
  output logic                       err_q,
  output logic                       pass_done_q
);

  localparam int IW = (NBYTES > 1) ? $clog2(NBYTES) : 1;

  logic [IW-1:0] idx_q;
  logic [2:0]    crc_q;
  logic [2:0]    crc_d;
  logic          last;

  // One byte through the x^3+x+1 divider, msb first
  function automatic logic [2:0] crc_byte(input logic [2:0] c,
                                          input logic [7:0] b);
    logic [2:0] r;
    logic       fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[2] ^ b[i];
      r  = {r[1:0], 1'b0} ^ (fb ? `SCM_CRC_POLY : 3'h0);
    end
    return r;
  endfunction

  assign crc_d = crc_byte(crc_q, data[idx_q*8 +: 8]);
  assign last  = (idx_q == IW'(NBYTES - 1));

  // Walk the array one byte a cycle, reseeding at each pass
  always_ff @(posedge core_clk) begin
    if (!reset_n || !enable) begin
      idx_q <= '0;
      crc_q <= `SCM_CRC_SEED;
    end else if (last) begin
      idx_q <= '0;
      crc_q <= `SCM_CRC_SEED;
    end else begin
      idx_q <= idx_q + IW'(1);
      crc_q <= crc_d;
    end
  end

  // Compare at the end of each pass
  always_ff @(posedge core_clk) begin
    if (!reset_n || !enable) begin
      err_q       <= 1'b0;
      pass_done_q <= 1'b0;
    end else begin
      pass_done_q <= last;
      if (last) begin
        err_q <= (crc_d != check_bits);
      end
    end
  end

endmodule

// ---- scm_master.sv ----
// Serial-interface master model issuing register reads and writes
`timescale 1ns/1ps
module scm_master (
  // Clock
  input  wire logic       clk,
  // Register port towards the monitor
  output logic            rd_en,
  output logic            wr_en,
  output logic [5:0]      addr,
  output logic [7:0]      wdata,
  input  wire logic [7:0] rdata,
  input  wire logic       rvalid
);
  // ********************
  // Bus cycles
  // ********************
  initial begin
    rd_en = 1'h0;
    wr_en = 1'h0;
    addr  = 6'h00;
    wdata = 8'h00;
  end
  // Strobe for one edge, take the answer just after the next edge
  task automatic rd(input logic [5:0] a, output logic [7:0] d,
                    output logic v);
    @(posedge clk);
    #1;
    rd_en = 1'h1;
    addr  = a;
    @(posedge clk);
    #1;
    v     = rvalid;
    d     = rdata;
    rd_en = 1'h0;
    addr  = ~a;  // Released address stops showing the old value
  endtask
  // Write to a reserved place carries zeros only
  task automatic wr(input logic [5:0] a);
    @(posedge clk);
    #1;
    wr_en = 1'h1;
    addr  = a;
    wdata = 8'h00;
    @(posedge clk);
    #1;
    wr_en = 1'h0;
    wdata = 8'hff;
    addr  = ~a;
  endtask
endmodule

// ---- scm_monitor.sv ----
// Status, tick count and CRC integrity monitor of a two-axis sensor
// Notes on behaviour
// - Saturation flag sets when either axis modulator saturates.
// - Status read clears the saturation flag.
// - Initializing flag holds from reset release until init completes.
// - Status read leaves the initializing flag alone.
// - Output mismatch fault sets its flag; status read clears it.
// - Axis offset limit sets that axis flag; status read clears it.
// - Reset-occurred flag sets during post-reset init; read clears it.
// - Tick register shows free 8-bit counter after 1024 prescaler.
// - Tick advances every 128 us and wraps every 32.768 ms.
// - Offset correction registers hold latest correction per axis.
// - Factory shadow array checked by CRC x^3+x+1, seed 111.
// - Writable array CRC runs only while end-of-init lock is set.
// - Writable array CRC x^3+x+1 seed 111 sets internal error.
// - Device held in reset until all supplies are within limits.
// - Digital regulator fault either flags reset or holds reset.
// - Status register read-only, bit 7 zero, bits 6..0 as mapped.
// - Read clears internal error; it reasserts while fault remains.
`timescale 1ns/1ps
`include "scm_regs.svh"

module scm_monitor
  import scm_pkg::*;
#(
  parameter int SHADOW_BYTES = 8,
  parameter int WRITE_BYTES  = 8,
  parameter int OSC_DIV      = `SCM_OSC_DIV_CYCLES
) (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      reset_n,
  // Register access from the serial interface
  input  wire logic                      reg_rd_en,
  input  wire logic                      reg_wr_en,
  input  wire logic [`SCM_ADDR_W-1:0]    reg_addr,
  input  wire logic [7:0]                reg_wdata,
  output logic [7:0]                     reg_rdata_q,
  output logic                           reg_rvalid_q,
  // Fault events and offset updates
  input  wire scm_events_t               events,
  input  wire scm_offcorr_t              x_offset_correction,
  input  wire scm_offcorr_t              y_offset_correction,
  // Supplies and initialization
  input  wire scm_supply_t               supply,
  input  wire logic                      init_done,
  input  wire logic                      end_of_init_lock_bit,
  // Arrays under CRC check
  input  wire logic [SHADOW_BYTES*8-1:0] shadow_data,
  input  wire logic [2:0]                shadow_check,
  input  wire logic [WRITE_BYTES*8-1:0]  write_data,
  input  wire logic [2:0]                write_check,
  // Device state
  output logic                           device_reset_q,
  output logic                           initializing_flag_q,
  output logic [7:0]                     status_register_q
);

  // ****************************************************************
  // Internal signals
  // ****************************************************************
  scm_state_t  state_q;
  logic        supplies_ok;
  logic        hold_reset;
  logic        dreg_flag_ev;
  logic        dev_rst_n;
  logic        status_read;
  logic        running;
  logic [7:0]  tick_count;
  logic        shadow_err;
  logic        write_err;
  logic        write_fault_q;
  logic        modulator_saturation_flag_q;
  logic        output_mismatch_flag_q;
  logic        x_offset_flag_q;
  logic        y_offset_flag_q;
  logic        reset_occurred_flag_q;
  logic        internal_error_flag_q;
  logic [7:0]  x_offset_correction_q;
  logic [7:0]  y_offset_correction_q;
  logic [7:0]  reserved_a_q;
  logic [7:0]  reserved_b_q;
  logic [7:0]  status_now;

  // Sticky flag update: a set in the clearing cycle wins
  function automatic logic flag_next(input logic cur,
                                     input logic set,
                                     input logic clr);
    return set | (cur & ~clr);
  endfunction

  // ****************************************************************
  // Supply monitor and device reset
  // ****************************************************************

  // Every supply inside its limits releases the device
  assign supplies_ok = supply.vext_ok & supply.vreg_ok
                     & supply.vrega_ok;
  // Regulator fault outcome chosen by the hold-mode input
  assign hold_reset   = supply.dreg_fault & supply.dreg_hold_mode;
  assign dreg_flag_ev = supply.dreg_fault & ~supply.dreg_hold_mode;
  assign dev_rst_n    = reset_n & supplies_ok & ~hold_reset;

  // Registered device reset state for the rest of the chip
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      device_reset_q <= 1'b1;
    end else begin
      device_reset_q <= ~dev_rst_n;
    end
  end

  // ****************************************************************
  // Life cycle: reset, initialization, run
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (!dev_rst_n) begin
      state_q <= SCM_ST_RESET;
    end else begin
      case (state_q)
        SCM_ST_RESET: begin
          state_q <= SCM_ST_INIT;
        end
        SCM_ST_INIT: begin
          if (init_done) begin
            state_q <= SCM_ST_RUN;
          end
        end
        SCM_ST_RUN: begin
          state_q <= SCM_ST_RUN;
        end
        default: begin
          state_q <= SCM_ST_RESET;
        end
      endcase
    end
  end

  assign running = (state_q != SCM_ST_RESET);

  // Initializing flag follows the init phase only, never the read
  always_ff @(posedge core_clk) begin
    if (!dev_rst_n) begin
      initializing_flag_q <= 1'b0;
    end else begin
      initializing_flag_q <= (state_q == SCM_ST_RESET) |
                             ((state_q == SCM_ST_INIT) & ~init_done);
    end
  end

  // ****************************************************************
  // Register read decode
  // ****************************************************************

  // Requests are ignored while the device sits in reset
  assign status_read = reg_rd_en & running &
                       (reg_addr == `SCM_OFF_STATUS);

  // Status image, bit 7 unused and read as zero
  always_comb begin
    status_now = 8'h00;
    status_now[`SCM_BIT_INT_ERR]    = internal_error_flag_q;
    status_now[`SCM_BIT_SATURATION] = modulator_saturation_flag_q;
    status_now[`SCM_BIT_INIT]       = initializing_flag_q;
    status_now[`SCM_BIT_MISMATCH]   = output_mismatch_flag_q;
    status_now[`SCM_BIT_Y_OFFSET]   = y_offset_flag_q;
    status_now[`SCM_BIT_X_OFFSET]   = x_offset_flag_q;
    status_now[`SCM_BIT_RESET_OCC]  = reset_occurred_flag_q;
  end

  // Status image mirrored out one cycle late; the read return uses status_now directly
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      status_register_q <= `SCM_RST_BYTE;
    end else begin
      status_register_q <= status_now;
    end
  end

  // ****************************************************************
  // Clear-on-read status flags
  // ****************************************************************

  // Saturation of either axis modulator
  always_ff @(posedge core_clk) begin
    if (!dev_rst_n) begin
      modulator_saturation_flag_q <= 1'b0;
    end else begin
      modulator_saturation_flag_q <= flag_next(
        modulator_saturation_flag_q,
        running & (events.sat_x | events.sat_y),
        status_read);
    end
  end

  // Serial output data mismatch
  always_ff @(posedge core_clk) begin
    if (!dev_rst_n) begin
      output_mismatch_flag_q <= 1'b0;
    end else begin
      output_mismatch_flag_q <= flag_next(output_mismatch_flag_q,
        running & events.miso_mismatch, status_read);
    end
  end

  // Offset monitor over range, one flag per axis
  always_ff @(posedge core_clk) begin
    if (!dev_rst_n) begin
      x_offset_flag_q <= 1'b0;
      y_offset_flag_q <= 1'b0;
    end else begin
      x_offset_flag_q <= flag_next(x_offset_flag_q,
        running & events.off_lim_x, status_read);
      y_offset_flag_q <= flag_next(y_offset_flag_q,
        running & events.off_lim_y, status_read);
    end
  end

  // Reset occurred: set on entry to init, or by a regulator fault
  always_ff @(posedge core_clk) begin
    if (!dev_rst_n) begin
      reset_occurred_flag_q <= 1'b0;
    end else begin
      reset_occurred_flag_q <= flag_next(reset_occurred_flag_q,
        (state_q == SCM_ST_RESET) | (running & dreg_flag_ev),
        status_read);
    end
  end

  // ****************************************************************
  // CRC integrity checks
  // ****************************************************************

  // Factory shadow array, always checked in the background
  scm_crc3_check #(
    .NBYTES      (SHADOW_BYTES)
  ) u_shadow_crc (
    .core_clk    (core_clk),
    .reset_n     (dev_rst_n),
    .enable      (1'b1),
    .data        (shadow_data),
    .check_bits  (shadow_check),
    .err_q       (shadow_err),
    .pass_done_q ()
  );

  // Writable array, checked only once the configuration is locked
  scm_crc3_check #(
    .NBYTES      (WRITE_BYTES)
  ) u_write_crc (
    .core_clk    (core_clk),
    .reset_n     (dev_rst_n),
    .enable      (end_of_init_lock_bit),
    .data        (write_data),
    .check_bits  (write_check),
    .err_q       (write_err),
    .pass_done_q ()
  );

  // Writable array fault latches until the next device reset
  always_ff @(posedge core_clk) begin
    if (!dev_rst_n) begin
      write_fault_q <= 1'b0;
    end else if (write_err) begin
      write_fault_q <= 1'b1;
    end
  end

  // Internal error: cleared by read, reasserted while a fault stands
  always_ff @(posedge core_clk) begin
    if (!dev_rst_n) begin
      internal_error_flag_q <= 1'b0;
    end else begin
      internal_error_flag_q <= flag_next(internal_error_flag_q,
        shadow_err | write_err | write_fault_q,
        status_read);
    end
  end

  // ****************************************************************
  // Oscillator tick counter
  // ****************************************************************
  scm_tick_counter #(
    .OSC_DIV  (OSC_DIV)
  ) u_tick (
    .core_clk (core_clk),
    .reset_n  (dev_rst_n),
    .count_q  (tick_count)
  );

  // ****************************************************************
  // Offset correction and reserved registers
  // ****************************************************************

  // Latest correction step from the offset cancellation circuit
  always_ff @(posedge core_clk) begin
    if (!dev_rst_n) begin
      x_offset_correction_q <= `SCM_RST_BYTE;
      y_offset_correction_q <= `SCM_RST_BYTE;
    end else begin
      if (x_offset_correction.valid) begin
        x_offset_correction_q <= x_offset_correction.value;
      end
      if (y_offset_correction.valid) begin
        y_offset_correction_q <= y_offset_correction.value;
      end
    end
  end

  // Reserved registers keep what the master writes; it writes zeros
  always_ff @(posedge core_clk) begin
    if (!dev_rst_n) begin
      reserved_a_q <= `SCM_RST_BYTE;
      reserved_b_q <= `SCM_RST_BYTE;
    end else if (reg_wr_en && running) begin
      if (reg_addr == `SCM_OFF_RSVD_A) begin
        reserved_a_q <= reg_wdata;
      end
      if (reg_addr == `SCM_OFF_RSVD_B) begin
        reserved_b_q <= reg_wdata;
      end
    end
  end

  // ****************************************************************
  // Read data return
  // ****************************************************************

  // One cycle after the read strobe; unmapped offsets return zero
  always_ff @(posedge core_clk) begin
    if (!dev_rst_n) begin
      reg_rdata_q  <= `SCM_RST_BYTE;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd_en & running;
      if (reg_rd_en && running) begin
        case (reg_addr)
          `SCM_OFF_STATUS:     reg_rdata_q <= status_now;
          `SCM_OFF_TICK_COUNT: reg_rdata_q <= tick_count;
          `SCM_OFF_X_CORR:     reg_rdata_q <= x_offset_correction_q;
          `SCM_OFF_Y_CORR:     reg_rdata_q <= y_offset_correction_q;
          `SCM_OFF_RSVD_A:     reg_rdata_q <= reserved_a_q;
          `SCM_OFF_RSVD_B:     reg_rdata_q <= reserved_b_q;
          default:             reg_rdata_q <= 8'h00;
        endcase
      end
    end
  end

endmodule

// ---- scm_monitor_test.sv ----
// Self-checking bench of the status, count and CRC monitor
`timescale 1ns/1ps
`include "scm_regs.svh"
module status_count_crc_monitor_test
  import scm_pkg::*;
;
  // ********************
  // Bench
  // ********************
  logic         core_clk, reset_n, rd_en, wr_en, init_done, lock, dres;
  logic         ifl, rvalid, v;
  logic [5:0]   addr;
  logic [7:0]   wdata, rdata, got, simg;
  logic [7:0]   vals[5] = '{8'h04, 8'h02, 8'h08, 8'h20, 8'h20};
  logic [5:0]   ra[6] = '{6'h15, 6'h16, 6'h17, 6'h1c, 6'h1d, 6'h3f};
  logic [63:0]  sd, wd;
  logic [2:0]   sc, wc;
  logic [31:0]  seed = 32'h1e;
  scm_events_t  ev;
  scm_offcorr_t ox, oy;
  scm_supply_t  sup;
  int           errors, compares, i, t0;
  // Model of the event flags: status bit set by each event input
  int           bp[5] = '{`SCM_BIT_Y_OFFSET, `SCM_BIT_X_OFFSET,
                          `SCM_BIT_MISMATCH, `SCM_BIT_SATURATION,
                          `SCM_BIT_SATURATION};
  int           mq[$];
  scm_monitor #(.OSC_DIV(1)) DUT (.core_clk(core_clk), .reset_n(reset_n),
    .reg_rd_en(rd_en), .reg_wr_en(wr_en), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata_q(rdata), .reg_rvalid_q(rvalid),
    .events(ev), .x_offset_correction(ox), .y_offset_correction(oy), .supply(sup),
    .init_done(init_done), .end_of_init_lock_bit(lock),
    .shadow_data(sd), .shadow_check(sc), .write_data(wd),
    .write_check(wc), .device_reset_q(dres), .initializing_flag_q(ifl),
    .status_register_q(simg));
  scm_master M (.clk(core_clk), .rd_en(rd_en), .wr_en(wr_en),
    .addr(addr), .wdata(wdata), .rdata(rdata), .rvalid(rvalid));
  // Clock and watchdog
  initial begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    #400000;
    errors++;
    final_report();
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Check bits: x^3+x+1, seed 111, byte 0 first, msb first
  function automatic logic [2:0] crc3(input logic [63:0] d);
    logic [2:0] c;
    c = 3'h7;
    for (int k = 0; k < 64; k++)
      c = {c[1:0], 1'h0} ^ ((c[2] ^ d[(k / 8) * 8 + 7 - k % 8]) ? 3'h3 : 3'h0);
    return c;
  endfunction
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("Error %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic rs(input logic [7:0] e);
    M.rd(`SCM_OFF_STATUS, got, v);
    chk({7'h0, v}, 8'h01);
    chk(got, e);
    chk(simg, e);
  endtask
  task automatic do_reset();
    reset_n = 1'h0;
    cyc(8);
    reset_n = 1'h1;
    cyc(3);
  endtask
  task automatic final_report();
    if (errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    reset_n = 1'h0;
    init_done = 1'h0;
    lock = 1'h0;
    ev = '0;
    ox = '0;
    oy = '0;
    sup = 5'h1c;
    sd = {xs(), xs()};
    wd = {xs(), xs()};
    sc = crc3(sd);
    wc = crc3(wd);
    do_reset();
    for (i = 0; i < 6; i++) begin
      M.rd(ra[i], got, v);
      chk(got, 8'h00);
    end
    rs(8'h11);
    rs(8'h10);
    init_done = 1'h1;
    cyc(1);
    init_done = 1'h0;
    cyc(2);
    chk({7'h0, ifl}, 8'h00);
    rs(8'h00);
    M.rd(`SCM_OFF_TICK_COUNT, got, v);
    for (i = 0; i < 3; i++) begin
      t0 = got;
      cyc(1022);
      M.rd(`SCM_OFF_TICK_COUNT, got, v);
      chk(got, 8'(t0 + 1));
    end
    for (i = 0; i < 5; i++) begin
      ev[i] = 1'h1;
      cyc(1);
      ev = '0;
      mq.push_back(1 << bp[i]);
      rs(vals[i]);
      chk(got, 8'(mq.pop_front()));
      rs(8'h00);
    end
    fork
      M.rd(`SCM_OFF_STATUS, got, v);
      begin
        cyc(1);
        ev.miso_mismatch = 1'h1;
        cyc(1);
        ev = '0;
      end
    join
    chk(got, 8'h00);
    rs(8'h08);
    t0 = xs();
    ox = {1'h1, 8'(t0)};
    oy = {1'h1, 8'(t0 >> 8)};
    cyc(1);
    ox = ~ox;
    oy = ~oy;
    M.rd(`SCM_OFF_X_CORR, got, v);
    chk(got, 8'(t0));
    M.rd(`SCM_OFF_Y_CORR, got, v);
    chk(got, 8'(t0 >> 8));
    M.wr(`SCM_OFF_RSVD_A);
    M.rd(`SCM_OFF_RSVD_A, got, v);
    chk(got, 8'h00);
    wc = wc ^ 3'h1;
    cyc(20);
    rs(8'h00);
    lock = 1'h1;
    cyc(20);
    rs(8'h40);
    wc = wc ^ 3'h1;
    cyc(20);
    rs(8'h40);
    do_reset();
    cyc(20);
    rs(8'h11);
    sc = sc ^ 3'h1;
    cyc(20);
    rs(8'h50);
    rs(8'h50);
    do_reset();
    cyc(20);
    rs(8'h51);
    sc = sc ^ 3'h1;
    cyc(20);
    rs(8'h50);
    rs(8'h10);
    sup.dreg_fault = 1'h1;
    cyc(2);
    sup.dreg_fault = 1'h0;
    cyc(2);
    chk({7'h0, dres}, 8'h00);
    rs(8'h11);
    sup.vreg_ok = 1'h0;
    cyc(2);
    chk({7'h0, dres}, 8'h01);
    M.rd(`SCM_OFF_STATUS, got, v);
    chk({7'h0, v}, 8'h00);
    sup.vreg_ok = 1'h1;
    cyc(4);
    rs(8'h11);
    sup = 5'h1f;
    cyc(3);
    chk({7'h0, dres}, 8'h01);
    final_report();
  end
endmodule

// ---- scm_pkg.sv ----
// Types shared by the status, count and CRC monitor
package scm_pkg;

  // Device life cycle seen by the monitor
  typedef enum logic [1:0] {
    SCM_ST_RESET,
    SCM_ST_INIT,
    SCM_ST_RUN
  } scm_state_t;

  // Fault and status events from the signal chain and interface
  typedef struct packed {
    logic sat_x;
    logic sat_y;
    logic miso_mismatch;
    logic off_lim_x;
    logic off_lim_y;
  } scm_events_t;

  // Supply monitor inputs
  typedef struct packed {
    logic vext_ok;
    logic vreg_ok;
    logic vrega_ok;
    logic dreg_fault;
    logic dreg_hold_mode;
  } scm_supply_t;

  // Offset cancellation update
  typedef struct packed {
    logic       valid;
    logic [7:0] value;
  } scm_offcorr_t;

endpackage

// ---- scm_regs.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef SCM_REGS_SVH
`define SCM_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define SCM_ADDR_W          6
`define SCM_OFF_STATUS      6'h14
`define SCM_OFF_TICK_COUNT  6'h15
`define SCM_OFF_X_CORR      6'h16
`define SCM_OFF_Y_CORR      6'h17
`define SCM_OFF_RSVD_A      6'h1c
`define SCM_OFF_RSVD_B      6'h1d

// ****************************************************************
// Status register bit positions
// ****************************************************************
`define SCM_BIT_RESET_OCC   0
`define SCM_BIT_X_OFFSET    1
`define SCM_BIT_Y_OFFSET    2
`define SCM_BIT_MISMATCH    3
`define SCM_BIT_INIT        4
`define SCM_BIT_SATURATION  5
`define SCM_BIT_INT_ERR     6

// ****************************************************************
// Reset values
// ****************************************************************
`define SCM_RST_BYTE        8'h00
`define SCM_RST_FLAGS       7'h00

// ****************************************************************
// CRC and timing
// ****************************************************************
`define SCM_CRC_SEED        3'h7
`define SCM_CRC_POLY        3'h3
`define SCM_CLK_PERIOD_NS   5
`define SCM_OSC_PERIOD_NS   125
`define SCM_OSC_DIV_CYCLES  (`SCM_OSC_PERIOD_NS / `SCM_CLK_PERIOD_NS)
`define SCM_PRESCALE_W      10
`define SCM_TICK_PERIOD_US  128
`define SCM_WRAP_PERIOD_US  32768

`endif

// ---- scm_tick_counter.sv ----
// Oscillator tick counter behind a 1024 prescaler
`timescale 1ns/1ps
`include "scm_regs.svh"

module scm_tick_counter
  import scm_pkg::*;
#(
  parameter int OSC_DIV = `SCM_OSC_DIV_CYCLES
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // Count value
  output logic [7:0]      count_q
);

  localparam int DW = (OSC_DIV > 1) ? $clog2(OSC_DIV) : 1;

  logic [DW-1:0]              osc_q;
  logic [`SCM_PRESCALE_W-1:0] pre_q;
  logic                       osc_tick;

  assign osc_tick = (osc_q == DW'(OSC_DIV - 1));

  // Primary oscillator period recovered from the core clock
  always_ff @(posedge core_clk) begin
    if (!reset_n || osc_tick) begin
      osc_q <= '0;
    end else begin
      osc_q <= osc_q + DW'(1);
    end
  end

  // Prescaler and free-running counter, wraps 255 to 0
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pre_q   <= '0;
      count_q <= `SCM_RST_BYTE;
    end else if (osc_tick) begin
      pre_q <= pre_q + `SCM_PRESCALE_W'(1);
      if (&pre_q) begin
        count_q <= count_q + 8'h01;
      end
    end
  end

endmodule
